// ==== verilog/pst_defines.vh ====
// constants for the four-port power sequencing timers
//
// Function
// - enable held low at least 120 us forces a whole-device hardware reset.
// - after switch turn-on, allow current limit for a 60 ms startup window.
// - after startup, allow overcurrent for the fault window, then shut off.
// - wait 80 ms for port voltage to reset before every detection attempt.
// - in injector mode, wait at least 2 s between detection attempts.
// - after overcurrent shutdown, non-injector mode, wait 0.96 s to repower.
// - in automatic mode, space any two port power-ups by 0.5 s.
// - fault window set per port by a four-bit setting, default 60 ms.
// - power-good flag set only after output held above threshold 4 ms.
`ifndef PST_DEFINES_VH
`define PST_DEFINES_VH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define PST_CLK_KHZ        25000
`define PST_MS_PER_TICK    1
`define PST_CYC_PER_MS     (`PST_CLK_KHZ * `PST_MS_PER_TICK)
`define PST_HWRST_US       120
`define PST_HWRST_CYC      ((`PST_HWRST_US * `PST_CLK_KHZ + 999) / 1000)

// ----------------------------------------------------------------
// timings in milliseconds
// ----------------------------------------------------------------
`define PST_DET_RESET_MS   80
`define PST_CLASS_MS       19
`define PST_STARTUP_MS     60
`define PST_INJ_GAP_MS     2000
`define PST_RESTART_MS     960
`define PST_SPACING_MS     500
`define PST_PG_FILTER_MS   4
`define PST_FAULT_STEP_MS  4

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define PST_REG_FAULT_TIME 8'h00
`define PST_REG_MODE       8'h04
`define PST_REG_PORT_EN    8'h08
`define PST_REG_STATUS     8'h0C
`define PST_MODE_AUTO_BIT  0
`define PST_MODE_INJ_BIT   1
`define PST_FAULT_TIME_RST 16'hFFFF
`define PST_MODE_RST       2'h1
`define PST_PORT_EN_RST    4'h0

`endif

// ==== verilog/pst_port_sequence_timers.v ====
// four-port detection, classification, power-up and fault sequencing timers
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "pst_defines.vh"

module pst_port_sequence_timers #(
	parameter CYC_PER_MS = `PST_CYC_PER_MS,
	parameter HWRST_CYC  = `PST_HWRST_CYC
) (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        en_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	input  wire [3:0]  det_done_i,
	input  wire [3:0]  det_valid_i,
	input  wire [3:0]  current_limit_i,
	input  wire [3:0]  overcurrent_i,
	input  wire [3:0]  vout_above_i,
	output reg         hw_reset_o,
	output reg  [3:0]  detect_on_o,
	output reg  [3:0]  class_on_o,
	output reg  [3:0]  gate_on_o,
	output reg  [3:0]  port_power_good_flag_o,
	output reg  [3:0]  fault_o
);

// ----------------------------------------------------------------
// port states
// ----------------------------------------------------------------
localparam [7:0] S_IDLE = 8'h01;
localparam [7:0] S_DRST = 8'h02;
localparam [7:0] S_DET  = 8'h04;
localparam [7:0] S_CLS  = 8'h08;
localparam [7:0] S_SEQ  = 8'h10;
localparam [7:0] S_STRT = 8'h20;
localparam [7:0] S_ON   = 8'h40;
localparam [7:0] S_WAIT = 8'h80;

// fault window in ms; a zero setting still gives one step
function [10:0] fault_ms;
	input [3:0] setting;
	begin
		if (setting == 4'h0)
			fault_ms = 11'h004;
		else
			fault_ms = {5'h00, setting, 2'h0};
	end
endfunction

// delay before a new detection attempt from the wait state
function [10:0] wait_ms;
	input inj;
	input fault;
	begin
		if (inj)
			wait_ms = 11'd`PST_INJ_GAP_MS;
		else if (fault)
			wait_ms = 11'd`PST_RESTART_MS;
		else
			wait_ms = 11'h000;
	end
endfunction

// ----------------------------------------------------------------
// enable-pin hardware reset
// ----------------------------------------------------------------
reg  [11:0] en_low_cnt_r;
reg         hw_rst_r;
wire        rst_all = rst_i | hw_rst_r;

always @(posedge sys_clk_i) begin
	if (rst_i) begin
		en_low_cnt_r <= 12'h000;
		hw_rst_r     <= 1'b0;
		hw_reset_o   <= 1'b0;
	end else if (en_i) begin
		en_low_cnt_r <= 12'h000;
		hw_rst_r     <= 1'b0;
		hw_reset_o   <= 1'b0;
	end else if (en_low_cnt_r >= HWRST_CYC[11:0] - 12'h001) begin
		hw_rst_r     <= 1'b1;
		hw_reset_o   <= 1'b1;
	end else begin
		en_low_cnt_r <= en_low_cnt_r + 12'h001;
	end
end

// ----------------------------------------------------------------
// millisecond tick
// ----------------------------------------------------------------
reg [15:0] pre_cnt_r;
reg        ms_tick_r;

always @(posedge sys_clk_i) begin
	if (rst_all) begin
		pre_cnt_r <= 16'h0000;
		ms_tick_r <= 1'b0;
	end else if (pre_cnt_r == CYC_PER_MS[15:0] - 16'h0001) begin
		pre_cnt_r <= 16'h0000;
		ms_tick_r <= 1'b1;
	end else begin
		pre_cnt_r <= pre_cnt_r + 16'h0001;
		ms_tick_r <= 1'b0;
	end
end

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [15:0] fault_time_setting_r;
reg [1:0]  mode_r;
reg [3:0]  port_en_r;
wire       auto_mode = mode_r[`PST_MODE_AUTO_BIT];
wire       inj_mode  = mode_r[`PST_MODE_INJ_BIT];

always @(posedge sys_clk_i) begin
	if (rst_all) begin
		fault_time_setting_r <= `PST_FAULT_TIME_RST;
		mode_r               <= `PST_MODE_RST;
		port_en_r            <= `PST_PORT_EN_RST;
		reg_rdata_o          <= 32'h0000_0000;
	end else begin
		if (reg_wr_i) begin
			case (reg_addr_i)
			`PST_REG_FAULT_TIME: fault_time_setting_r <= reg_wdata_i[15:0];
			`PST_REG_MODE:       mode_r <= reg_wdata_i[1:0];
			`PST_REG_PORT_EN:    port_en_r <= reg_wdata_i[3:0];
			default:             ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
			`PST_REG_FAULT_TIME:
				reg_rdata_o <= {16'h0000, fault_time_setting_r};
			`PST_REG_MODE:       reg_rdata_o <= {30'h0, mode_r};
			`PST_REG_PORT_EN:    reg_rdata_o <= {28'h0, port_en_r};
			`PST_REG_STATUS:
				reg_rdata_o <= {20'h0, fault_o, port_power_good_flag_o,
					gate_on_o};
			default:             reg_rdata_o <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end
end

// ----------------------------------------------------------------
// shared power-up spacing
// ----------------------------------------------------------------
reg [7:0]  st_r    [0:3];
reg [10:0] tmr_r   [0:3];
reg [10:0] oc_ms_r [0:3];
reg [2:0]  pg_ms_r [0:3];
reg [9:0]  spacing_r;
reg [3:0]  grant;
reg        taken;
integer    g;

// lowest waiting port wins; manual mode never holds a port back
always @* begin
	grant = 4'h0;
	taken = 1'b0;
	for (g = 0; g < 4; g = g + 1) begin
		if (st_r[g] == S_SEQ && !taken &&
			(!auto_mode || spacing_r == 10'h000)) begin
			grant[g] = 1'b1;
			taken    = auto_mode;
		end
	end
end

always @(posedge sys_clk_i) begin
	if (rst_all)
		spacing_r <= 10'h000;
	else if (auto_mode && grant != 4'h0)
		spacing_r <= 10'd`PST_SPACING_MS;
	else if (ms_tick_r && spacing_r != 10'h000)
		spacing_r <= spacing_r - 10'h001;
end

// ----------------------------------------------------------------
// per-port sequencers
// ----------------------------------------------------------------
integer p;

always @(posedge sys_clk_i) begin
	for (p = 0; p < 4; p = p + 1) begin
		if (rst_all) begin
			st_r[p]                   <= S_IDLE;
			tmr_r[p]                  <= 11'h000;
			oc_ms_r[p]                <= 11'h000;
			pg_ms_r[p]                <= 3'h0;
			detect_on_o[p]            <= 1'b0;
			class_on_o[p]             <= 1'b0;
			gate_on_o[p]              <= 1'b0;
			port_power_good_flag_o[p] <= 1'b0;
			fault_o[p]                <= 1'b0;
		end else begin
			if (ms_tick_r && tmr_r[p] != 11'h000)
				tmr_r[p] <= tmr_r[p] - 11'h001;
			case (st_r[p])
			S_IDLE: begin
				if (auto_mode || port_en_r[p]) begin
					st_r[p]  <= S_DRST;
					tmr_r[p] <= 11'd`PST_DET_RESET_MS;
				end
			end
			S_DRST: begin
				if (tmr_r[p] == 11'h000) begin
					st_r[p]        <= S_DET;
					detect_on_o[p] <= 1'b1;
				end
			end
			S_DET: begin
				if (det_done_i[p]) begin
					detect_on_o[p] <= 1'b0;
					if (det_valid_i[p]) begin
						st_r[p]       <= S_CLS;
						class_on_o[p] <= 1'b1;
						tmr_r[p]      <= 11'd`PST_CLASS_MS;
					end else begin
						st_r[p]  <= S_WAIT;
						tmr_r[p] <= wait_ms(inj_mode, 1'b0);
					end
				end
			end
			S_CLS: begin
				if (tmr_r[p] == 11'h000) begin
					class_on_o[p] <= 1'b0;
					st_r[p]       <= S_SEQ;
				end
			end
			S_SEQ: begin
				if (grant[p]) begin
					st_r[p]      <= S_STRT;
					gate_on_o[p] <= 1'b1;
					fault_o[p]   <= 1'b0;
					tmr_r[p]     <= 11'd`PST_STARTUP_MS;
				end
			end
			S_STRT: begin
				if (tmr_r[p] == 11'h000) begin
					// still limiting after startup is a fault
					if (current_limit_i[p]) begin
						st_r[p]      <= S_WAIT;
						gate_on_o[p] <= 1'b0;
						fault_o[p]   <= 1'b1;
						tmr_r[p]     <= wait_ms(inj_mode, 1'b1);
					end else begin
						st_r[p]    <= S_ON;
						oc_ms_r[p] <= 11'h000;
					end
				end
			end
			S_ON: begin
				if (!overcurrent_i[p])
					oc_ms_r[p] <= 11'h000;
				else if (ms_tick_r)
					oc_ms_r[p] <= oc_ms_r[p] + 11'h001;
				if (overcurrent_i[p] && oc_ms_r[p] >=
					fault_ms(fault_time_setting_r[4*p +: 4])) begin
					st_r[p]      <= S_WAIT;
					gate_on_o[p] <= 1'b0;
					fault_o[p]   <= 1'b1;
					tmr_r[p]     <= wait_ms(inj_mode, 1'b1);
				end else if (!auto_mode && !port_en_r[p]) begin
					st_r[p]      <= S_IDLE;
					gate_on_o[p] <= 1'b0;
				end
			end
			S_WAIT: begin
				if (tmr_r[p] == 11'h000)
					st_r[p] <= S_IDLE;
			end
			default: st_r[p] <= S_IDLE;
			endcase
			// power good after 4 ms above threshold
			if (!gate_on_o[p] || !vout_above_i[p]) begin
				pg_ms_r[p]                <= 3'h0;
				port_power_good_flag_o[p] <= 1'b0;
			end else if (pg_ms_r[p] == 3'd`PST_PG_FILTER_MS) begin
				port_power_good_flag_o[p] <= 1'b1;
			end else if (ms_tick_r) begin
				pg_ms_r[p] <= pg_ms_r[p] + 3'h1;
			end
		end
	end
end

endmodule

// ==== verification/pst_chk.sv ====
// property checker for the port sequencing timers
`timescale 1ns/1ns
module pst_chk #(
	parameter CYC_PER_MS = 25000,
	parameter HWRST_CYC  = 3000
) (
	input wire        sys_clk_i,
	input wire        rst_i,
	input wire        en_i,
	input wire [3:0]  vout_above_i,
	input wire        hw_reset_o,
	input wire [3:0]  detect_on_o,
	input wire [3:0]  class_on_o,
	input wire [3:0]  gate_on_o,
	input wire [3:0]  port_power_good_flag_o,
	input wire [3:0]  fault_o
);
	int  c_en, c_idle, c_cls, c_on, c_pg, c_flt;
	wire x = rst_i | hw_reset_o;
	wire busy = detect_on_o[0] | class_on_o[0] | gate_on_o[0];
	// ----------------------------------------------------------------
	// enable-low and port 0 state age counters
	// ----------------------------------------------------------------
	always @(posedge sys_clk_i) begin
		c_en <= (rst_i || en_i) ? 0 : c_en + 1;
		c_idle <= (x || busy) ? 0 : c_idle + 1;
		c_cls <= (x || !class_on_o[0]) ? 0 : c_cls + 1;
		c_on <= (x || !gate_on_o[0]) ? 0 : c_on + 1;
		c_pg <= (x || !(gate_on_o[0] & vout_above_i[0])) ? 0 : c_pg + 1;
		c_flt <= (x || !fault_o[0]) ? 0 : c_flt + 1;
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	// a pulse cut short by hw reset would look like a short window
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (x);
	sequence s_hw_exit;
		hw_reset_o && en_i;
	endsequence
	a_hwrst_late: assert property (disable iff (rst_i)
		$rose(hw_reset_o) |-> c_en >= HWRST_CYC - 1) else $error("hw reset early");
	a_hwrst_hold: assert property (disable iff (rst_i)
		hw_reset_o && !en_i |=> hw_reset_o) else $error("hw reset dropped");
	a_hwrst_exit: assert property (disable iff (rst_i)
		s_hw_exit |=> !hw_reset_o) else $error("hw reset stuck");
	a_det_reset: assert property ($rose(detect_on_o[0])
		|-> c_idle >= 79 * CYC_PER_MS) else $error("detect too early");
	a_class_len: assert property ($fell(class_on_o[0])
		|-> c_cls >= 18 * CYC_PER_MS && c_cls <= 25 * CYC_PER_MS)
		else $error("class window length");
	a_start_win: assert property ($rose(fault_o[0])
		|-> c_on >= 59 * CYC_PER_MS) else $error("fault too early");
	a_restart_gap: assert property ($rose(gate_on_o[0])
		&& $past(fault_o[0]) |-> c_flt >= 959 * CYC_PER_MS)
		else $error("restart too early");
	a_pg_filter: assert property ($rose(port_power_good_flag_o[0])
		|-> c_pg >= 3 * CYC_PER_MS) else $error("power good early");
	a_pg_drop: assert property (!vout_above_i[0]
		|=> !port_power_good_flag_o[0]) else $error("power good held");
endmodule

bind pst_port_sequence_timers pst_chk #(
	.CYC_PER_MS(CYC_PER_MS), .HWRST_CYC(HWRST_CYC)) i_pst_chk (
	.sys_clk_i, .rst_i, .en_i, .vout_above_i, .hw_reset_o, .detect_on_o,
	.class_on_o, .gate_on_o, .port_power_good_flag_o, .fault_o);

// ==== verification/pst_pd_model.sv ====
// behavioural powered devices on the four ports
`timescale 1ns/1ns
module pst_pd_model (
	input  wire       sys_clk_i,
	input  wire [3:0] detect_on_i,
	input  wire [3:0] gate_on_i,
	input  wire [3:0] valid_cfg_i,
	input  wire [3:0] lim_cfg_i,
	input  wire [3:0] oc_cfg_i,
	output reg  [3:0] det_done_o,
	output wire [3:0] det_valid_o,
	output wire [3:0] current_limit_o,
	output wire [3:0] overcurrent_o,
	output reg  [3:0] vout_above_o
);
	reg [3:0] d1  = 4'h0;
	reg [3:0] tgl = 4'h5;
	initial det_done_o = 4'h0;
	initial vout_above_o = 4'h0;
	// result is junk outside the done pulse so it cannot be relied on
	assign det_valid_o = det_done_o & valid_cfg_i | ~det_done_o & tgl;
	assign current_limit_o = lim_cfg_i & gate_on_i;
	assign overcurrent_o = oc_cfg_i & gate_on_i;
	always @(posedge sys_clk_i) begin
		d1 <= detect_on_i;
		tgl <= ~tgl;
		det_done_o <= detect_on_i & d1 & ~det_done_o;
		vout_above_o <= gate_on_i;
	end
endmodule

// ==== verification/pst_port_sequence_timers_test.sv ====
// self-checking bench for the port sequencing timers
`timescale 1ns/1ns
module pst_port_sequence_timers_test;
	localparam M = 10;
	localparam H = 16;
	reg          sys_clk_i = 1'b0;
	reg          rst_i     = 1'b1;
	reg          en_i      = 1'b1;
	reg  [7:0]   addr      = 8'h00;
	reg  [31:0]  wdata     = 32'h0;
	reg          wr        = 1'b0;
	reg          rd        = 1'b0;
	reg  [3:0]   vcfg      = 4'h3;
	reg  [3:0]   lcfg      = 4'h0;
	reg  [3:0]   ocfg      = 4'h0;
	wire [31:0]  rdata;
	wire [3:0]   dd, dv, cl, oc, va, det, cls, gate, pg, flt;
	wire         hwr;
	int          err_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          t, t0, i;
	logic [31:0] d;
	logic [72:0] tab [0:8] = '{
		{1'b0, 8'h00, 32'h0, 32'h0000FFFF}, {1'b0, 8'h04, 32'h0, 32'h1},
		{1'b0, 8'h08, 32'h0, 32'h0}, {1'b1, 8'h20, 32'hFFFFFFFF, 32'h0},
		{1'b0, 8'h20, 32'h0, 32'h0}, {1'b1, 8'h00, 32'h2, 32'h0},
		{1'b0, 8'h00, 32'h0, 32'h2}, {1'b1, 8'h0C, 32'hFFF, 32'h0},
		{1'b0, 8'h0C, 32'h0, 32'h0}};

	pst_port_sequence_timers #(.CYC_PER_MS(M), .HWRST_CYC(H))
		i_pst_port_sequence_timers (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .det_done_i(dd),
		.det_valid_i(dv), .current_limit_i(cl), .overcurrent_i(oc),
		.vout_above_i(va), .hw_reset_o(hwr), .detect_on_o(det),
		.class_on_o(cls), .gate_on_o(gate),
		.port_power_good_flag_o(pg), .fault_o(flt));
	pst_pd_model i_pst_pd_model (
		.sys_clk_i(sys_clk_i), .detect_on_i(det), .gate_on_i(gate),
		.valid_cfg_i(vcfg), .lim_cfg_i(lcfg), .oc_cfg_i(ocfg),
		.det_done_o(dd), .det_valid_o(dv), .current_limit_o(cl),
		.overcurrent_o(oc), .vout_above_o(va));

	always #20 sys_clk_i = ~sys_clk_i;
	// ceiling sits well above the longest expected run
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count = err_count + 1;
			close_out;
		end
	end

	task close_out;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_i);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge sys_clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	function logic pick(input int k, p);
		case (k)
			0: pick = det[p];
			1: pick = cls[p];
			2: pick = gate[p];
			3: pick = pg[p];
			default: pick = flt[p];
		endcase
	endfunction
	task hold(input int k, p, input logic v, output int n);
		n = 0;
		while (pick(k, p) !== v && n < 30000) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk("wait", n < 30000, 1);
	endtask
	function logic in_ms(input int n, lo, hi);
		in_ms = n >= lo * M && n <= hi * M;
	endfunction

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		#1 t0 = cyc;
		for (i = 0; i < 9; i++) begin
			bus(tab[i][72], tab[i][71:64], tab[i][63:32]);
			if (!tab[i][72]) chk("reg", d, tab[i][31:0]);
		end
		$display("test regs done");
		hold(0, 0, 1, t);
		chk("drst", in_ms(cyc - t0, 79, 82), 1);
		hold(1, 0, 1, t);
		hold(1, 0, 0, t);
		chk("class", in_ms(t, 18, 20), 1);
		hold(2, 0, 1, t);
		t0 = cyc;
		hold(3, 0, 1, t);
		chk("pwr_good", in_ms(t, 3, 6), 1);
		bus(1'b0, 8'h0C, 32'h0);
		chk("status", d, 32'h00000011);
		hold(2, 1, 1, t);
		chk("spacing", in_ms(cyc - t0, 499, 502), 1);
		@(posedge sys_clk_i) ocfg <= 4'h1;
		hold(4, 0, 1, t);
		chk("oc_win", in_ms(t, 7, 10), 1);
		chk("oc_off", gate[0], 0);
		@(posedge sys_clk_i) ocfg <= 4'h0;
		t0 = cyc;
		hold(2, 0, 1, t);
		chk("restart", in_ms(cyc - t0, 1055, 1063), 1);
		@(posedge sys_clk_i) vcfg <= 4'hF;
		lcfg <= 4'h4;
		bus(1'b1, 8'h04, 32'h3);
		hold(2, 2, 1, t);
		hold(4, 2, 1, t);
		chk("startup", in_ms(t, 59, 62), 1);
		hold(0, 2, 1, t);
		chk("inj_gap", in_ms(t, 2079, 2083), 1);
		$display("test sequence done");
		@(posedge sys_clk_i) en_i <= 1'b0;
		repeat (H - 4) @(posedge sys_clk_i);
		en_i <= 1'b1;
		@(posedge sys_clk_i) en_i <= 1'b0;
		#1 chk("short", hwr, 0);
		repeat (H + 3) @(posedge sys_clk_i);
		#1 chk("hwrst", hwr, 1);
		chk("hw_off", gate, 0);
		@(posedge sys_clk_i) en_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		bus(1'b0, 8'h00, 32'h0);
		chk("hw_regs", d, 32'h0000FFFF);
		$display("test hwreset done");
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h08, 32'h2);
		@(posedge sys_clk_i) ocfg <= 4'h2;
		hold(2, 0, 1, t);
		chk("manual", gate, 32'hF);
		hold(2, 0, 0, t);
		chk("man_off", flt, 32'h4);
		hold(4, 1, 1, t);
		chk("oc_dflt", in_ms(t, 59, 62), 1);
		$display("test manual done");
		close_out;
	end
endmodule
